/* File: inc/ioe_regs.svh */
// Purpose: offsets, fields, reset values and counts of the expander access block
// Assumes: byte offsets on a 12-bit register address
// Notes: definitions only
`ifndef IOE_REGS_SVH
`define IOE_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define IOE_CS_OFS 12'h430
`define IOE_AD0_OFS 12'h434
`define IOE_AD1_OFS 12'h438
`define IOE_ISTS_OFS 12'h440
`define IOE_IMSK_OFS 12'h444

// ----------------------------------------
// control/status fields
// ----------------------------------------
`define IOE_PINS_LSB 0
`define IOE_PINS_W 16
`define IOE_REFRESH_BIT 24
`define IOE_TM_BIT 25
`define IOE_SEL_LSB 26
`define IOE_SEL_W 4
`define IOE_DONE_BIT 31

// ----------------------------------------
// address config fields
// ----------------------------------------
`define IOE_DADDR_W 7
`define IOE_DADDR_LSB 1
`define IOE_DADDR_STRIDE 8
`define IOE_AD0_SLOTS 3
`define IOE_AD1_SLOT 4

// ----------------------------------------
// select codes and slot count
// ----------------------------------------
`define IOE_NSLOT 5
`define IOE_SEL_MAX 4'h4
`define IOE_SEL_RSVD 4'h3

// ----------------------------------------
// interrupt bits and reset values
// ----------------------------------------
`define IOE_IRQ_W 2
`define IOE_IRQ_DONE_BIT 0
`define IOE_IRQ_REFUSE_BIT 1
`define IOE_CS_RST 32'h0000_0000
`define IOE_IRQ_RST 2'h0

`endif

/* File: inc/ioe_pkg.sv */
// Purpose: types shared by the expander access block
// Assumes: nothing
// Notes: constants live in ioe_regs.svh
package ioe_pkg;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic {
		ioe_seq_idle,
		ioe_seq_busy
	} ioe_seq_st_t;

	typedef logic [15:0] ioe_pins_t;
	typedef logic [6:0] ioe_daddr_t;

endpackage

/* File: src/ioe_txn_seq.sv */
// Purpose: picks one pending expander and runs one bus transaction for it
// Assumes: engine holds off eng_done until eng_req has been seen
// Notes: lowest pending slot wins
module ioe_txn_seq #(
	parameter int NSLOT = 5,
	parameter int IW = 3
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [NSLOT-1:0] pend,
	input wire logic eng_done,
	output logic eng_req_q,
	output logic [IW-1:0] slot_q,
	output logic [IW-1:0] pick,
	output logic launch,
	output logic finish
);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	if (NSLOT < 1 || NSLOT > (1 << IW)) begin : g_chk
		$error("slot count does not fit index width");
	end

	// ----------------------------------------
	// arbitration
	// ----------------------------------------
	function automatic logic [IW-1:0] first_set(input logic [NSLOT-1:0] v);
		logic [IW-1:0] r;
		r = '0;
		for (int i = NSLOT - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = IW'(i);
			end
		end
		return r;
	endfunction

	ioe_pkg::ioe_seq_st_t state_q;
	wire idle = (state_q == ioe_pkg::ioe_seq_idle);

	assign pick = first_set(pend);
	assign launch = idle && (|pend);
	// a done pulse while idle is stray and ignored
	assign finish = !idle && eng_done;

	// ----------------------------------------
	// state
	// ----------------------------------------
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= ioe_pkg::ioe_seq_idle;
			eng_req_q <= 1'b0;
			slot_q <= '0;
		end else begin
			case (state_q)
				ioe_pkg::ioe_seq_idle: begin
					if (launch) begin
						state_q <= ioe_pkg::ioe_seq_busy;
						eng_req_q <= 1'b1;
						slot_q <= pick;
					end
				end
				ioe_pkg::ioe_seq_busy: begin
					if (finish) begin
						state_q <= ioe_pkg::ioe_seq_idle;
						eng_req_q <= 1'b0;
					end
				end
				default: begin
					state_q <= ioe_pkg::ioe_seq_idle;
					eng_req_q <= 1'b0;
				end
			endcase
		end
	end

endmodule // ioe_txn_seq

/* File: src/ioe_access_ctrl.sv */
// Purpose: control/status and address registers of the bus I/O expander interface
// Assumes: an external bus master engine runs each transaction and pulses eng_done
// Notes: one transaction in flight; output values are latched when it starts
//
// Overview of operation
// - pin field reads selected expander's last values
// - pin writes ignored unless test mode set
// - test mode refresh sends software output values
// - input bits of pin field stay read-only
// - refresh write launches update transaction
// - refresh bit always reads zero
// - test mode replaces core outputs with software values
// - four-bit select chooses expander, some codes reserved
// - done set when selected refresh finishes
// - done set when test mode update finishes
// - done set when the address init of the selected expander finishes
// - done stays set until written one
// - each expander addressed by its configured address
//
// The implementer's own choice: the strobed register port.
`include "ioe_regs.svh"

module ioe_access_ctrl #(
	parameter int AW = 12
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic eng_req,
	output logic [6:0] eng_dev_addr,
	output logic eng_init,
	output logic [15:0] eng_out_vals,
	input wire logic eng_done,
	input wire logic [15:0] eng_in_vals,
	input wire logic [`IOE_NSLOT*16-1:0] exp_out_mask,
	input wire logic [`IOE_NSLOT*16-1:0] core_out_vals,
	output logic irq
);

	localparam int NSLOT = `IOE_NSLOT;
	localparam int IW = 3;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	if (AW < 12) begin : g_chk
		$error("register address too narrow for the map");
	end

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic rst_s1_q;
	logic rst_s2_q;
	wire rst_sync_b = rst_s2_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// codes 3 and 5..15 name no expander
	function automatic logic sel_ok(input logic [3:0] s);
		return (s <= `IOE_SEL_MAX) && (s != `IOE_SEL_RSVD);
	endfunction

	function automatic logic [15:0] slice16(input logic [NSLOT*16-1:0] v, input logic [IW-1:0] i);
		return v[i*16 +: 16];
	endfunction

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	wire hit_cs = (reg_addr[11:0] == `IOE_CS_OFS);
	wire hit_ad0 = (reg_addr[11:0] == `IOE_AD0_OFS);
	wire hit_ad1 = (reg_addr[11:0] == `IOE_AD1_OFS);
	wire hit_ists = (reg_addr[11:0] == `IOE_ISTS_OFS);
	wire hit_imsk = (reg_addr[11:0] == `IOE_IMSK_OFS);
	wire upper_zero = (AW == 12) || (reg_addr >> 12) == '0;

	wire wr_cs = reg_wr && hit_cs && upper_zero;
	wire wr_ad0 = reg_wr && hit_ad0 && upper_zero;
	wire wr_ad1 = reg_wr && hit_ad1 && upper_zero;
	wire wr_ists = reg_wr && hit_ists && upper_zero;
	wire wr_imsk = reg_wr && hit_imsk && upper_zero;

	// ----------------------------------------
	// control/status fields
	// ----------------------------------------
	logic [3:0] sel_q;
	logic tm_q;
	logic done_q;

	wire [3:0] wr_sel = reg_wdata[`IOE_SEL_LSB +: `IOE_SEL_W];
	wire wr_tm = reg_wdata[`IOE_TM_BIT];
	wire wr_refresh = reg_wdata[`IOE_REFRESH_BIT];
	wire wr_done_clr = reg_wdata[`IOE_DONE_BIT];
	wire [15:0] wr_pins = reg_wdata[`IOE_PINS_LSB +: `IOE_PINS_W];

	// the select written in the same access is the one acted on
	wire new_sel_ok = sel_ok(wr_sel);
	wire [IW-1:0] new_slot = wr_sel[IW-1:0];
	wire cur_sel_ok = sel_ok(sel_q);
	wire [IW-1:0] cur_slot = sel_q[IW-1:0];

	// refresh is a command, not stored state
	wire refresh_req = wr_cs && wr_refresh;
	// pin write counts only while the written test mode bit is set
	wire pins_req = wr_cs && wr_tm;
	wire slot_req = (refresh_req || pins_req) && new_sel_ok;
	wire refused = (refresh_req || pins_req) && !new_sel_ok;

	// ----------------------------------------
	// sequencer
	// ----------------------------------------
	logic [NSLOT-1:0] pend_q;
	logic [NSLOT-1:0] init_q;
	logic [IW-1:0] seq_slot;
	logic [IW-1:0] seq_pick;
	logic seq_launch;
	logic seq_finish;
	logic seq_req_q;

	ioe_txn_seq #(
		.NSLOT(NSLOT),
		.IW(IW)
	) u_seq (
		.clk(clk),
		.rst_b(rst_sync_b),
		.pend(pend_q),
		.eng_done(eng_done),
		.eng_req_q(seq_req_q),
		.slot_q(seq_slot),
		.pick(seq_pick),
		.launch(seq_launch),
		.finish(seq_finish)
	);

	// ----------------------------------------
	// per-expander state
	// ----------------------------------------
	logic [NSLOT*16-1:0] pins_flat;
	logic [NSLOT*16-1:0] sw_flat;
	logic [NSLOT*7-1:0] daddr_flat;

	for (genvar i = 0; i < NSLOT; i++) begin : g_slot
		localparam logic [IW-1:0] IDX = IW'(i);
		localparam bit IN_AD0 = (i < `IOE_AD0_SLOTS);
		localparam bit IN_AD1 = (i == `IOE_AD1_SLOT);
		localparam int FLSB = IN_AD0 ? (`IOE_DADDR_LSB + i * `IOE_DADDR_STRIDE) : `IOE_DADDR_LSB;

		logic [15:0] pins_q;
		logic [15:0] sw_q;
		logic [6:0] daddr_q;
		logic pnd_q;
		logic ini_q;

		wire [15:0] omask = exp_out_mask[i*16 +: 16];
		wire addr_wr = (IN_AD0 && wr_ad0) || (IN_AD1 && wr_ad1);
		wire req_set = (slot_req && new_slot == IDX) || addr_wr;
		wire taken = seq_launch && seq_pick == IDX;
		wire ended = seq_finish && seq_slot == IDX;
		wire pins_wr = pins_req && new_sel_ok && new_slot == IDX;

		// a request landing on its own launch stays pending and reruns
		always_ff @(posedge clk or negedge rst_sync_b) begin
			if (!rst_sync_b) begin
				pnd_q <= 1'b0;
			end else begin
				pnd_q <= req_set || (pnd_q && !taken);
			end
		end

		always_ff @(posedge clk or negedge rst_sync_b) begin
			if (!rst_sync_b) begin
				ini_q <= 1'b0;
			end else begin
				ini_q <= addr_wr || (ini_q && !taken);
			end
		end

		always_ff @(posedge clk or negedge rst_sync_b) begin
			if (!rst_sync_b) begin
				sw_q <= 16'h0000;
			end else if (pins_wr) begin
				sw_q <= wr_pins & omask;
			end
		end

		// inputs from the answer, outputs as they were sent
		always_ff @(posedge clk or negedge rst_sync_b) begin
			if (!rst_sync_b) begin
				pins_q <= 16'h0000;
			end else if (ended) begin
				pins_q <= (eng_in_vals & ~omask) | (eng_out_vals & omask);
			end
		end

		always_ff @(posedge clk or negedge rst_sync_b) begin
			if (!rst_sync_b) begin
				daddr_q <= 7'h00;
			end else if (addr_wr) begin
				daddr_q <= reg_wdata[FLSB +: `IOE_DADDR_W];
			end
		end

		assign pins_flat[i*16 +: 16] = pins_q;
		assign sw_flat[i*16 +: 16] = sw_q;
		assign daddr_flat[i*7 +: 7] = daddr_q;
		assign pend_q[i] = pnd_q;
		assign init_q[i] = ini_q;
	end

	// ----------------------------------------
	// engine request
	// ----------------------------------------
	// values frozen at launch so a late write cannot tear a transfer
	wire [15:0] pick_mask = slice16(exp_out_mask, seq_pick);
	wire [15:0] pick_core = slice16(core_out_vals, seq_pick);
	wire [15:0] pick_sw = slice16(sw_flat, seq_pick);
	wire [15:0] pick_out = (tm_q ? pick_sw : pick_core) & pick_mask;
	wire [6:0] pick_daddr = daddr_flat[seq_pick*7 +: 7];

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			eng_out_vals <= 16'h0000;
		end else if (seq_launch) begin
			eng_out_vals <= pick_out;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			eng_dev_addr <= 7'h00;
		end else if (seq_launch) begin
			eng_dev_addr <= pick_daddr;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			eng_init <= 1'b0;
		end else if (seq_launch) begin
			eng_init <= init_q[seq_pick];
		end
	end

	assign eng_req = seq_req_q;

	// ----------------------------------------
	// control register and done flag
	// ----------------------------------------
	// any finish on the expander now selected raises done
	wire done_set = seq_finish && cur_sel_ok && seq_slot == cur_slot;
	wire done_clr = wr_cs && wr_done_clr;

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			sel_q <= 4'(`IOE_CS_RST >> `IOE_SEL_LSB);
		end else if (wr_cs) begin
			sel_q <= wr_sel;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			tm_q <= 1'b0;
		end else if (wr_cs) begin
			tm_q <= wr_tm;
		end
	end

	// set beats clear in the same cycle
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			done_q <= 1'b0;
		end else begin
			done_q <= done_set || (done_q && !done_clr);
		end
	end

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	logic [`IOE_IRQ_W-1:0] ists_q;
	logic [`IOE_IRQ_W-1:0] imsk_q;

	wire [`IOE_IRQ_W-1:0] ev = {refused, done_set};
	wire [`IOE_IRQ_W-1:0] ists_clr = wr_ists ? reg_wdata[`IOE_IRQ_W-1:0] : '0;

	// event beats a clear written in the same cycle
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ists_q <= `IOE_IRQ_RST;
		end else begin
			ists_q <= ev | (ists_q & ~ists_clr);
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			imsk_q <= `IOE_IRQ_RST;
		end else if (wr_imsk) begin
			imsk_q <= reg_wdata[`IOE_IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			irq <= 1'b0;
		end else begin
			irq <= |(ists_q & imsk_q);
		end
	end

	// ----------------------------------------
	// read path
	// ----------------------------------------
	wire [15:0] pins_rd = cur_sel_ok ? slice16(pins_flat, cur_slot) : 16'h0000;
	// refresh bit position is hard zero
	wire [31:0] rd_cs = {done_q, 1'b0, sel_q, tm_q, 1'b0, 8'h00, pins_rd};
	wire [31:0] rd_ad0 = {8'h00, daddr_flat[20:14], 1'b0, daddr_flat[13:7], 1'b0, daddr_flat[6:0], 1'b0};
	wire [31:0] rd_ad1 = {24'h00_0000, daddr_flat[`IOE_AD1_SLOT*7 +: 7], 1'b0};
	wire [31:0] rd_ists = {30'h0000_0000, ists_q};
	wire [31:0] rd_imsk = {30'h0000_0000, imsk_q};
	wire [31:0] rd_sel = !upper_zero ? 32'h0000_0000 :
		hit_cs ? rd_cs :
		hit_ad0 ? rd_ad0 :
		hit_ad1 ? rd_ad1 :
		hit_ists ? rd_ists :
		hit_imsk ? rd_imsk : 32'h0000_0000;

	// data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= reg_rd ? rd_sel : 32'h0000_0000;
		end
	end

endmodule // ioe_access_ctrl

/* File: dv/ioe_exp_model.sv */
// Purpose: behavioural bus engine with the expanders behind it
// Assumes: one request at a time, held until done is taken
// Notes: input lines scramble outside the done cycle
module ioe_exp_model (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic eng_req,
	input wire logic [6:0] eng_dev_addr,
	input wire logic slow,
	output logic eng_done,
	output logic [15:0] eng_in_vals
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] cnt_q;
	logic [15:0] pat;
	// --------------------------------
	// answer
	// --------------------------------
	// inverse outside done so a late sample never matches by luck
	assign pat = {eng_dev_addr, 2'h2, ~eng_dev_addr};
	assign eng_in_vals = eng_done ? pat : ~pat;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_q <= 5'h0;
			eng_done <= 1'b0;
		end else begin
			eng_done <= 1'b0;
			if (eng_req && !eng_done) begin
				cnt_q <= cnt_q + 5'h1;
				if (cnt_q == (slow ? 5'h0C : 5'h01)) begin
					eng_done <= 1'b1;
					cnt_q <= 5'h0;
				end
			end
		end
	end
endmodule // ioe_exp_model

/* File: dv/ioe_access_ctrl_assertions.sv */
// Purpose: port-level checks of the expander access block
// Assumes: strobes one cycle long
// Notes: engine slot is not visible here, so per-slot checks live in the bench
`include "ioe_regs.svh"
module ioe_access_ctrl_assertions #(
	parameter int AW = 12
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [AW-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic eng_req,
	input wire logic [6:0] eng_dev_addr,
	input wire logic eng_init,
	input wire logic [15:0] eng_out_vals,
	input wire logic eng_done,
	input wire logic [15:0] eng_in_vals,
	input wire logic [`IOE_NSLOT*16-1:0] exp_out_mask,
	input wire logic [`IOE_NSLOT*16-1:0] core_out_vals,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic sel_ok;
	logic msk_wr;
	// --------------------------------
	// helpers
	// --------------------------------
	assign sel_ok = reg_wdata[29:26] <= 4'h2 || reg_wdata[29:26] == `IOE_SEL_MAX;
	assign msk_wr = reg_wr && reg_addr == `IOE_IMSK_OFS;
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	sequence s_refresh;
		reg_wr && reg_addr == `IOE_CS_OFS && reg_wdata[24] && sel_ok && !eng_req;
	endsequence
	sequence s_mask_off;
		msk_wr && reg_wdata[1:0] == 2'h0 ##1 !msk_wr;
	endsequence
	sequence s_txn_end;
		eng_req && eng_done;
	endsequence
	// --------------------------------
	// checks
	// --------------------------------
	AST_RD_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside read cycle");
	AST_RD_CS: assert property ($past(reg_rd) && $past(reg_addr) == `IOE_CS_OFS |-> reg_rdata[24:16] == 9'h0)
		else $error("refresh or reserved bits read nonzero");
	AST_RD_UNMAP: assert property ($past(reg_rd) && $past(reg_addr) == 12'h000 |-> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	AST_REQ_HOLD: assert property (eng_req && !eng_done |=> eng_req && $stable(eng_dev_addr) && $stable(eng_out_vals))
		else $error("request dropped or changed before done");
	AST_REQ_END: assert property (s_txn_end |=> !eng_req)
		else $error("request still high after done");
	AST_REFRESH_GO: assert property (s_refresh |-> ##[1:4] eng_req)
		else $error("refresh did not launch");
	AST_INIT_GO: assert property (reg_wr && reg_addr == `IOE_AD1_OFS && !eng_req |-> ##[1:4] eng_req)
		else $error("address write did not launch init");
	AST_IRQ_OFF: assert property (s_mask_off |-> ##1 !irq)
		else $error("interrupt high with all masked");
endmodule // ioe_access_ctrl_assertions

/* File: dv/io_expander_access_control_test.sv */
// Purpose: self-checking bench of the expander access block
// Assumes: model answers every request
// Notes: random pins and masks mixed with refused and test mode cases
`include "ioe_regs.svh"
module io_expander_access_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_b, reg_wr, reg_rd, eng_req, eng_init, eng_done, irq, slow;
	logic [11:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, seed;
	logic [15:0] eng_out_vals, eng_in_vals, m, o;
	logic [6:0] eng_dev_addr;
	logic [79:0] exp_out_mask, core_out_vals;
	logic [6:0] ad [5];
	logic [11:0] ofs [6] = '{12'h430, 12'h434, 12'h438, 12'h440, 12'h444, 12'h000};
	int codes [4] = '{0, 1, 2, 4};
	int rsv [4] = '{3, 5, 6, 7};
	int error_cnt, n_compared, s;
	ioe_access_ctrl #(.AW(12)) uut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eng_req(eng_req), .eng_dev_addr(eng_dev_addr),
		.eng_init(eng_init), .eng_out_vals(eng_out_vals), .eng_done(eng_done), .eng_in_vals(eng_in_vals),
		.exp_out_mask(exp_out_mask), .core_out_vals(core_out_vals), .irq(irq));
	ioe_exp_model u_exp (.clk(clk), .rst_b(rst_b), .eng_req(eng_req), .eng_dev_addr(eng_dev_addr), .slow(slow),
		.eng_done(eng_done), .eng_in_vals(eng_in_vals));
	always #10 clk = ~clk;
	// --------------------------------
	// helpers
	// --------------------------------
	function automatic logic [31:0] nxt(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic logic [15:0] pins(input logic [6:0] a, input logic [15:0] mk, input logic [15:0] ov);
		return ({a, 2'h2, ~a} & ~mk) | (ov & mk);
	endfunction
	task automatic close_out;
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask
	// one idle cycle after each strobe keeps a driver from touching it twice
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e, input logic [31:0] mk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk(nm, e & mk, reg_rdata & mk);
		@(posedge clk);
	endtask
	task automatic wait_req(input logic v);
		int i;
		for (i = 0; i < 300 && eng_req !== v; i++)
			@(posedge clk) #1;
		if (i == 300) begin
			error_cnt++;
			close_out();
		end
	endtask
	task automatic txn(input logic [6:0] a, input logic [15:0] ov, input logic ini);
		#1;
		wait_req(1'b1);
		chk("eng_dev_addr", {25'h0, a}, {25'h0, eng_dev_addr});
		chk("eng_out_vals", {16'h0, ov}, {16'h0, eng_out_vals});
		chk("eng_init", {31'h0, ini}, {31'h0, eng_init});
		wait_req(1'b0);
		@(posedge clk);
	endtask
	task automatic rnd;
		seed = nxt(nxt(seed));
		exp_out_mask <= {seed, ~seed, seed[31:16]};
		seed = nxt(nxt(seed));
		core_out_vals <= {~seed, seed, seed[15:0]};
	endtask
	// --------------------------------
	// sequence
	// --------------------------------
	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		reg_addr = 12'h0;
		reg_wdata = 32'h0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		slow = 1'b0;
		exp_out_mask = 80'h0;
		core_out_vals = 80'h0;
		seed = 32'h4AC4D7F9;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		foreach (ofs[k]) rd("reset value", ofs[k], 32'h0, 32'hFFFF_FFFF);
		$display("test reset values done");
		rnd();
		for (s = 0; s < 5; s++) begin
			seed = nxt(seed);
			ad[s] = seed[6:0];
		end
		wr(`IOE_AD0_OFS, {8'h0, ad[2], 1'b0, ad[1], 1'b0, ad[0], 1'b0});
		for (s = 0; s < 3; s++) txn(ad[s], core_out_vals[s*16 +: 16] & exp_out_mask[s*16 +: 16], 1'b1);
		wr(`IOE_AD1_OFS, {24'h0, ad[4], 1'b0});
		txn(ad[4], core_out_vals[64 +: 16] & exp_out_mask[64 +: 16], 1'b1);
		rd("addr1", `IOE_AD1_OFS, {24'h0, ad[4], 1'b0}, 32'h0000_00FE);
		rd("done after init", `IOE_CS_OFS, 32'h8000_0000, 32'hBC00_0000);
		wr(`IOE_CS_OFS, 32'h0);
		rd("done kept", `IOE_CS_OFS, 32'h8000_0000, 32'h8000_0000);
		wr(`IOE_CS_OFS, 32'h8000_0000);
		rd("done cleared", `IOE_CS_OFS, 32'h0, 32'h8000_0000);
		$display("test address init done");
		foreach (codes[k]) begin
			s = codes[k];
			slow <= k[0];
			rnd();
			wr(`IOE_CS_OFS, (32'(s) << 26) | 32'h0100_0000);
			m = exp_out_mask[s*16 +: 16];
			o = core_out_vals[s*16 +: 16] & m;
			txn(ad[s], o, 1'b0);
			rd("refresh", `IOE_CS_OFS, 32'h8000_0000 | (32'(s) << 26) | pins(ad[s], m, o), 32'hFFFF_FFFF);
			wr(`IOE_CS_OFS, 32'h8000_0000 | (32'(s) << 26));
		end
		$display("test refresh done");
		seed = nxt(seed);
		m = exp_out_mask[16 +: 16];
		o = seed[15:0] & m;
		wr(`IOE_CS_OFS, 32'h0600_0000 | seed[15:0]);
		txn(ad[1], o, 1'b0);
		rd("test mode", `IOE_CS_OFS, 32'h8600_0000 | pins(ad[1], m, o), 32'hFFFF_FFFF);
		o = ~seed[15:0] & m;
		wr(`IOE_CS_OFS, {16'h8700, ~seed[15:0]});
		txn(ad[1], o, 1'b0);
		rd("test refresh", `IOE_CS_OFS, 32'h8600_0000 | pins(ad[1], m, o), 32'hFFFF_FFFF);
		wr(`IOE_CS_OFS, 32'h8400_FFFF);
		rd("pins ignored", `IOE_CS_OFS, 32'h0400_0000 | pins(ad[1], m, o), 32'hFFFF_FFFF);
		$display("test override done");
		wr(`IOE_IMSK_OFS, 32'h3);
		wr(`IOE_ISTS_OFS, 32'h3);
		foreach (rsv[k]) begin
			wr(`IOE_CS_OFS, (32'(rsv[k]) << 26) | 32'h0100_0000);
			repeat (1) @(posedge clk);
			#1;
			chk("no request", 32'h0, {31'h0, eng_req});
			@(posedge clk);
		end
		chk("irq refused", 32'h1, {31'h0, irq});
		rd("status", `IOE_ISTS_OFS, 32'h2, 32'h3);
		wr(`IOE_ISTS_OFS, 32'h2);
		#1;
		chk("irq cleared", 32'h0, {31'h0, irq});
		@(posedge clk);
		$display("test reserved select done");
		wr(`IOE_IMSK_OFS, 32'h0);
		slow <= 1'b1;
		wr(`IOE_CS_OFS, 32'h0900_0000);
		wr(`IOE_CS_OFS, 32'h0);
		txn(ad[2], exp_out_mask[32 +: 16] & core_out_vals[32 +: 16], 1'b0);
		rd("done other slot", `IOE_CS_OFS, 32'h0, 32'hBC00_0000);
		chk("irq masked", 32'h0, {31'h0, irq});
		$display("test select change done");
		close_out();
	end
endmodule // io_expander_access_control_test

bind ioe_access_ctrl ioe_access_ctrl_assertions #(.AW(AW)) u_chk (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eng_req(eng_req),
	.eng_dev_addr(eng_dev_addr), .eng_init(eng_init), .eng_out_vals(eng_out_vals), .eng_done(eng_done),
	.eng_in_vals(eng_in_vals), .exp_out_mask(exp_out_mask), .core_out_vals(core_out_vals), .irq(irq));
